// ==== bench/eag_core_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks
module eag_core_monitor
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire eag_pkg::eag_req_t req,
  input wire logic res_valid,
  input wire eag_pkg::eag_res_t res,
  input wire logic [23:1] addr_bus,
  input wire logic [31:0] long_next_addr,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic flag_wr,
  input wire logic [4:0] flag_val,
  input wire logic [15:0] status_word,
  input wire logic supervisor,
  input wire logic trace_active,
  input wire logic [2:0] irq_mask,
  input wire logic [4:0] cond_flags
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    req_valid;
  endsequence
  sequence s_abs_long_take;
    req_valid && req.mode == eag_pkg::eag_m_abs_long;
  endsequence
  property p_answer; s_take |=> res_valid; endproperty
  a_answer: assert property (p_answer) else $error("no result after request");
  property p_quiet; !req_valid |=> !res_valid && $stable(res); endproperty
  a_quiet: assert property (p_quiet) else $error("result changed without request");
  property p_abs; s_abs_long_take |=> res.effective_address == {$past(req.ext_hi), $past(req.ext_lo)}; endproperty
  a_abs: assert property (p_abs) else $error("absolute long address wrong");
  property p_bus; addr_bus == res.effective_address[23:1]; endproperty
  a_bus: assert property (p_bus) else $error("address bus differs from address");
  property p_next; res_valid |-> long_next_addr == res.effective_address + 32'h2; endproperty
  a_next: assert property (p_next) else $error("second word address wrong");
  property p_rdata; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");
  property p_fields;
    {trace_active, supervisor, irq_mask, cond_flags} ==
    {status_word[15], status_word[13], status_word[10:8], status_word[4:0]};
  endproperty
  a_fields: assert property (p_fields) else $error("status outputs differ from word");
  property p_flag; flag_wr && !(reg_wr && reg_addr == 5'h12) |=> cond_flags == $past(flag_val); endproperty
  a_flag: assert property (p_flag) else $error("flag write lost");
  property p_resv; (status_word & ~16'ha71f) == 16'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved status bit set");
endmodule // eag_core_monitor
bind eag_core eag_core_monitor u_eag_core_monitor (.core_clk(core_clk), .reset_n(reset_n),
  .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res), .addr_bus(addr_bus),
  .long_next_addr(long_next_addr), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flag_wr(flag_wr), .flag_val(flag_val), .status_word(status_word),
  .supervisor(supervisor), .trace_active(trace_active), .irq_mask(irq_mask), .cond_flags(cond_flags));
`default_nettype wire

// ==== bench/eag_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module eag_core_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid;
  eag_pkg::eag_req_t req;
  logic res_valid;
  eag_pkg::eag_res_t res;
  logic [4:0] reg_addr = 5'h0;
  logic [31:0] reg_wdata = 32'h0;
  eag_pkg::eag_size_t reg_size = eag_pkg::eag_sz_long;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic flag_wr = 1'b0;
  logic [4:0] flag_val = 5'h0;
  logic [15:0] status_word;
  logic supervisor;
  logic trace_active;
  logic [2:0] irq_mask;
  logic [31:0] program_counter;
  logic [4:0] cond_flags;
  int fail_count = 0;
  int checks_done = 0;
  always #2.5 core_clk = ~core_clk;
  eag_seq_model u_eag_seq_model (.core_clk(core_clk), .req_valid(req_valid), .req(req));
  eag_core u_eag_core (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .res_valid(res_valid), .res(res), .addr_bus(), .long_next_addr(), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flag_wr(flag_wr), .flag_val(flag_val), .status_word(status_word), .program_counter(program_counter),
    .supervisor(supervisor), .trace_active(trace_active), .irq_mask(irq_mask), .cond_flags(cond_flags));
  // ==========================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input eag_pkg::eag_size_t sz);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_size <= sz;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic ea(input eag_pkg::eag_mode_t m, input logic [2:0] rn, input eag_pkg::eag_size_t sz,
                    input logic [4:0] ix, input logic [15:0] hi, input logic [15:0] lo, input logic [31:0] exp,
                    input logic il = 1'b1);
    u_eag_seq_model.send(m, rn, sz, ix, hi, lo, il);
    #1;
    chk("res_valid", 32'(res_valid), 32'h1);
    chk("effective_address", res.effective_address, exp);
  endtask
  task automatic opnd(input eag_pkg::eag_mode_t m, input logic [2:0] rn, input eag_pkg::eag_size_t sz,
                      input logic [15:0] hi, input logic [15:0] lo, input logic [31:0] exp);
    ea(m, rn, sz, 5'h0, hi, lo, 32'h0);
    chk("is_mem", 32'(res.is_mem), 32'h0);
    chk("operand", res.operand, exp);
  endtask
  task automatic flags(input logic [4:0] v);
    @(posedge core_clk);
    flag_wr <= 1'b1;
    flag_val <= v;
    @(posedge core_clk);
    flag_wr <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    chk("status_word", 32'(status_word), 32'h2700);
    chk("irq_mask", 32'(irq_mask), 32'h7);
    chk("supervisor", 32'(supervisor), 32'h1);
    rd(5'h11, 32'h0);
    rd(5'h1f, 32'h0);
  endtask
  task automatic t_regs;
    wr(5'h00, 32'h1122_3344, eag_pkg::eag_sz_long);
    wr(5'h00, 32'hffff_ffaa, eag_pkg::eag_sz_byte);
    rd(5'h00, 32'h1122_33aa);
    wr(5'h00, 32'h0000_beef, eag_pkg::eag_sz_word);
    rd(5'h00, 32'h1122_beef);
    wr(5'h09, 32'h0000_8000, eag_pkg::eag_sz_word);
    rd(5'h09, 32'hffff_8000);
  endtask
  task automatic t_modes;
    wr(5'h0a, 32'h0000_1000, eag_pkg::eag_sz_long);
    wr(5'h03, 32'h0000_0010, eag_pkg::eag_sz_long);
    wr(5'h11, 32'h0000_2000, eag_pkg::eag_sz_long);
    wr(5'h08, 32'h0000_0040, eag_pkg::eag_sz_long);
    ea(eag_pkg::eag_m_ind, 3'h2, eag_pkg::eag_sz_word, 5'h0, 16'h0, 16'h0, 32'h0000_1000);
    ea(eag_pkg::eag_m_ind_d16, 3'h2, eag_pkg::eag_sz_word, 5'h0, 16'hfffe, 16'h0, 32'h0000_0ffe);
    ea(eag_pkg::eag_m_ind_idx, 3'h2, eag_pkg::eag_sz_word, 5'h3, 16'h0080, 16'h0, 32'h0000_0f90);
    ea(eag_pkg::eag_m_pc_d16, 3'h0, eag_pkg::eag_sz_word, 5'h0, 16'h0100, 16'h0, 32'h0000_2100);
    ea(eag_pkg::eag_m_pc_idx, 3'h0, eag_pkg::eag_sz_word, 5'h8, 16'h007f, 16'h0, 32'h0000_20bf);
    ea(eag_pkg::eag_m_abs_short, 3'h0, eag_pkg::eag_sz_word, 5'h0, 16'h8000, 16'h0, 32'hffff_8000);
    ea(eag_pkg::eag_m_abs_long, 3'h0, eag_pkg::eag_sz_long, 5'h0, 16'h0012, 16'h3456, 32'h0012_3456);
    ea(eag_pkg::eag_m_postinc, 3'h2, eag_pkg::eag_sz_long, 5'h0, 16'h0, 16'h0, 32'h0000_1000);
    rd(5'h0a, 32'h0000_1004);
    ea(eag_pkg::eag_m_predec, 3'h2, eag_pkg::eag_sz_byte, 5'h0, 16'h0, 16'h0, 32'h0000_1003);
    chk("addr_err", 32'(res.addr_err), 32'h0);
    ea(eag_pkg::eag_m_ind, 3'h2, eag_pkg::eag_sz_word, 5'h0, 16'h0, 16'h0, 32'h0000_1003);
    chk("addr_err", 32'(res.addr_err), 32'h1);
  endtask
  task automatic t_status;
    @(posedge core_clk);
    flag_wr <= 1'b1;
    flag_val <= 5'h15;
    @(posedge core_clk);
    flag_wr <= 1'b0;
    rd(5'h12, 32'h0000_2715);
    wr(5'h12, 32'h0000_ffff, eag_pkg::eag_sz_word);
    rd(5'h12, 32'h0000_a71f);
    chk("trace_active", 32'(trace_active), 32'h1);
  endtask
  task automatic t_operands;
    chk("program_counter", program_counter, 32'h0000_2000);
    opnd(eag_pkg::eag_m_dreg, 3'h0, eag_pkg::eag_sz_byte, 16'h0, 16'h0, 32'h0000_00ef);
    opnd(eag_pkg::eag_m_dreg, 3'h0, eag_pkg::eag_sz_word, 16'h0, 16'h0, 32'h0000_beef);
    opnd(eag_pkg::eag_m_areg, 3'h1, eag_pkg::eag_sz_word, 16'h0, 16'h0, 32'hffff_8000);
    opnd(eag_pkg::eag_m_imm, 3'h0, eag_pkg::eag_sz_long, 16'h1234, 16'h5678, 32'h1234_5678);
    opnd(eag_pkg::eag_m_imm, 3'h0, eag_pkg::eag_sz_byte, 16'h12ab, 16'h0, 32'h0000_00ab);
    opnd(eag_pkg::eag_m_quick, 3'h0, eag_pkg::eag_sz_long, 16'h00fe, 16'h0, 32'hffff_fffe);
    opnd(eag_pkg::eag_m_implied, 3'h0, eag_pkg::eag_sz_word, 16'h0, 16'h0, 32'h0000_2700);
    opnd(eag_pkg::eag_m_implied, 3'h3, eag_pkg::eag_sz_long, 16'h0, 16'h0, 32'h0000_2000);
    wr(5'h0f, 32'h0000_3000, eag_pkg::eag_sz_long);
    wr(5'h10, 32'h0000_4000, eag_pkg::eag_sz_long);
    ea(eag_pkg::eag_m_postinc, 3'h7, eag_pkg::eag_sz_word, 5'h0, 16'h0, 16'h0, 32'h0000_4000);
    rd(5'h10, 32'h0000_4002);
    rd(5'h0f, 32'h0000_3000);
    opnd(eag_pkg::eag_m_implied, 3'h1, eag_pkg::eag_sz_long, 16'h0, 16'h0, 32'h0000_3000);
    opnd(eag_pkg::eag_m_implied, 3'h2, eag_pkg::eag_sz_long, 16'h0, 16'h0, 32'h0000_4002);
    ea(eag_pkg::eag_m_ind_idx, 3'h0, eag_pkg::eag_sz_word, 5'h10, 16'h0, 16'h0, 32'h0000_4042);
    ea(eag_pkg::eag_m_ind_idx, 3'h0, eag_pkg::eag_sz_word, 5'h00, 16'h0, 16'h0, 32'hffff_bf2f, 1'b0);
  endtask
  task automatic t_collide;
    fork
      ea(eag_pkg::eag_m_postinc, 3'h0, eag_pkg::eag_sz_long, 5'h0, 16'h0, 16'h0, 32'h0000_0040);
      wr(5'h08, 32'h0000_9999, eag_pkg::eag_sz_long);
    join
    rd(5'h08, 32'h0000_0044);
    fork
      flags(5'h0a);
      wr(5'h12, 32'h0000_2700, eag_pkg::eag_sz_word);
    join
    rd(5'h12, 32'h0000_2700);
    wr(5'h12, 32'hffff_ffff, eag_pkg::eag_sz_byte);
    rd(5'h12, 32'h0000_271f);
    chk("cond_flags", 32'(cond_flags), 32'h0000_001f);
  endtask
  initial
  begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    t_reset();
    t_regs();
    t_modes();
    t_operands();
    t_status();
    t_collide();
    report_and_stop();
  end
endmodule // eag_core_tb
`default_nettype wire

// ==== bench/eag_seq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sequencer side: one-cycle requests
module eag_seq_model
(
  input wire logic core_clk,
  output logic req_valid,
  output eag_pkg::eag_req_t req
);
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  task automatic send(input eag_pkg::eag_mode_t m, input logic [2:0] rn, input eag_pkg::eag_size_t sz,
                      input logic [4:0] ix, input logic [15:0] hi, input logic [15:0] lo,
                      input logic il = 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{mode: m, reg_num: rn, size: sz, idx_sel: ix, idx_long: il, ext_hi: hi, ext_lo: lo};
    @(posedge core_clk);
    req_valid <= 1'b0;
    // Stale fields must not look valid
    req <= ~req;
  endtask
endmodule // eag_seq_model
`default_nettype wire

// ==== core/eag_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eag_defs.svh"

module eag_core
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire eag_pkg::eag_req_t req,
  output logic res_valid,
  output eag_pkg::eag_res_t res,
  output logic [23:1] addr_bus,
  output logic [31:0] long_next_addr,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire eag_pkg::eag_size_t reg_size,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic flag_wr,
  input wire logic [4:0] flag_val,
  output logic [15:0] status_word,
  output logic [31:0] program_counter,
  output logic supervisor,
  output logic trace_active,
  output logic [2:0] irq_mask,
  output logic [4:0] cond_flags
);

  // ==========================================
  // Programmer-visible state
  logic [31:0] data_r [0:7];
  logic [31:0] addr_r [0:6];
  logic [31:0] usp_r;
  logic [31:0] ssp_r;
  logic [31:0] pc_r;
  logic [15:0] sw_r;
  logic [31:0] reg_rdata_r;
  logic res_valid_r;
  eag_pkg::eag_res_t res_r;
  logic [31:0] long_next_r;

  logic [31:0] base;
  logic [31:0] index;
  logic [31:0] ea;
  logic [31:0] base_nxt;
  logic base_upd;
  logic is_mem;
  logic upd_en;
  logic [31:0] operand_nxt;
  eag_pkg::eag_res_t res_nxt;

  // ==========================================
  // Shared decoding
  function automatic logic [31:0] active_sp();
    return sw_r[`EAG_SW_S] ? ssp_r : usp_r;
  endfunction

  function automatic logic [31:0] addr_reg_value(input logic [2:0] num);
    logic [31:0] v;
    v = 32'h0;
    if (num == 3'h7)
    begin
      v = active_sp();
    end
    else
    begin
      v = addr_r[num];
    end
    return v;
  endfunction

  function automatic logic [31:0] read_reg(input logic [4:0] sel);
    logic [31:0] v;
    v = 32'h0;
    if (sel < `EAG_SEL_A0)
    begin
      v = data_r[sel[2:0]];
    end
    else if (sel < `EAG_SEL_USP)
    begin
      v = addr_r[3'(sel - `EAG_SEL_A0)];
    end
    else if (sel == `EAG_SEL_USP)
    begin
      v = usp_r;
    end
    else if (sel == `EAG_SEL_SSP)
    begin
      v = ssp_r;
    end
    else if (sel == `EAG_SEL_PC)
    begin
      v = pc_r;
    end
    else if (sel == `EAG_SEL_SW)
    begin
      v = {16'h0, sw_r};
    end
    return v;
  endfunction

  function automatic logic [31:0] fit_data(input logic [31:0] old, input logic [31:0] v,
                                           input eag_pkg::eag_size_t sz);
    logic [31:0] r;
    r = v;
    case (sz)
      eag_pkg::eag_sz_byte: r = {old[31:8], v[7:0]};
      eag_pkg::eag_sz_word: r = {old[31:16], v[15:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] fit_addr(input logic [31:0] v, input eag_pkg::eag_size_t sz);
    return (sz == eag_pkg::eag_sz_long) ? v : {{16{v[15]}}, v[15:0]};
  endfunction

  function automatic logic port_hit(input logic [4:0] sel);
    return reg_wr && (reg_addr == sel);
  endfunction

  // ==========================================
  // Address arithmetic
  always_comb
  begin
    base = addr_reg_value(req.reg_num);
    index = read_reg(req.idx_sel);
  end

  eag_ea_calc u_calc
  (
    .req(req),
    .base(base),
    .pc(pc_r),
    .index(index),
    .ea(ea),
    .base_nxt(base_nxt),
    .base_upd(base_upd),
    .is_mem(is_mem)
  );

  assign upd_en = req_valid && base_upd;

  // ==========================================
  // Operand selection for non-memory modes
  always_comb
  begin
    operand_nxt = 32'h0;
    case (req.mode)
      eag_pkg::eag_m_dreg:
      begin
        case (req.size)
          eag_pkg::eag_sz_byte: operand_nxt = {24'h0, data_r[req.reg_num][7:0]};
          eag_pkg::eag_sz_word: operand_nxt = {16'h0, data_r[req.reg_num][15:0]};
          default: operand_nxt = data_r[req.reg_num];
        endcase
      end
      eag_pkg::eag_m_areg:
      begin
        operand_nxt = fit_addr(base, req.size);
      end
      eag_pkg::eag_m_imm:
      begin
        case (req.size)
          eag_pkg::eag_sz_byte: operand_nxt = {24'h0, req.ext_hi[7:0]};
          eag_pkg::eag_sz_word: operand_nxt = {16'h0, req.ext_hi};
          default: operand_nxt = {req.ext_hi, req.ext_lo};
        endcase
      end
      eag_pkg::eag_m_quick:
      begin
        operand_nxt = {{24{req.ext_hi[7]}}, req.ext_hi[7:0]};
      end
      eag_pkg::eag_m_implied:
      begin
        case (req.reg_num[1:0])
          2'h0: operand_nxt = {16'h0, sw_r};
          2'h1: operand_nxt = usp_r;
          2'h2: operand_nxt = active_sp();
          default: operand_nxt = pc_r;
        endcase
      end
      default: operand_nxt = 32'h0;
    endcase
  end

  always_comb
  begin
    res_nxt.effective_address = ea;
    res_nxt.operand = operand_nxt;
    res_nxt.is_mem = is_mem;
    res_nxt.addr_err = is_mem && (req.size != eag_pkg::eag_sz_byte) && ea[0];
  end

  // ==========================================
  // Data register bank
  genvar gd;
  generate
    for (gd = 0; gd < 8; gd++)
    begin : g_data
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          data_r[gd] <= `EAG_REG_RST;
        end
        else if (port_hit(`EAG_SEL_D0 + 5'(gd)))
        begin
          data_r[gd] <= fit_data(data_r[gd], reg_wdata, reg_size);
        end
      end
    end
  endgenerate

  // ==========================================
  // Address register bank
  genvar ga;
  generate
    for (ga = 0; ga < 7; ga++)
    begin : g_addr
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          addr_r[ga] <= `EAG_REG_RST;
        end
        else if (upd_en && (req.reg_num == 3'(ga)))
        begin
          addr_r[ga] <= base_nxt;
        end
        else if (port_hit(`EAG_SEL_A0 + 5'(ga)))
        begin
          addr_r[ga] <= fit_addr(reg_wdata, reg_size);
        end
      end
    end
  endgenerate

  // ==========================================
  // Stack pointers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      usp_r <= `EAG_REG_RST;
    end
    else if (upd_en && (req.reg_num == 3'h7) && !sw_r[`EAG_SW_S])
    begin
      usp_r <= base_nxt;
    end
    else if (port_hit(`EAG_SEL_USP))
    begin
      usp_r <= fit_addr(reg_wdata, reg_size);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ssp_r <= `EAG_REG_RST;
    end
    else if (upd_en && (req.reg_num == 3'h7) && sw_r[`EAG_SW_S])
    begin
      ssp_r <= base_nxt;
    end
    else if (port_hit(`EAG_SEL_SSP))
    begin
      ssp_r <= fit_addr(reg_wdata, reg_size);
    end
  end

  // ==========================================
  // Program counter and status word
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_r <= `EAG_PC_RST;
    end
    else if (port_hit(`EAG_SEL_PC))
    begin
      pc_r <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sw_r <= `EAG_SW_RST;
    end
    else if (port_hit(`EAG_SEL_SW))
    begin
      if (reg_size == eag_pkg::eag_sz_byte)
      begin
        sw_r[7:0] <= reg_wdata[7:0] & 8'(`EAG_SW_IMPL);
      end
      else
      begin
        sw_r <= reg_wdata[15:0] & `EAG_SW_IMPL;
      end
    end
    else if (flag_wr)
    begin
      sw_r[`EAG_SW_X:`EAG_SW_C] <= flag_val;
    end
  end

  // ==========================================
  // Register port read, one cycle late
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata_r <= 32'h0;
    end
    else
    begin
      reg_rdata_r <= reg_rd ? read_reg(reg_addr) : 32'h0;
    end
  end

  // ==========================================
  // Result register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      res_valid_r <= 1'b0;
      res_r <= '0;
      long_next_r <= 32'h0;
    end
    else
    begin
      res_valid_r <= req_valid;
      if (req_valid)
      begin
        res_r <= res_nxt;
        long_next_r <= ea + `EAG_LONG_NEXT;
      end
    end
  end

  // ==========================================
  // Outputs
  assign res_valid = res_valid_r;
  assign res = res_r;
  assign addr_bus = res_r.effective_address[`EAG_ABUS_HI:`EAG_ABUS_LO];
  assign long_next_addr = long_next_r;
  assign reg_rdata = reg_rdata_r;
  assign status_word = sw_r;
  assign program_counter = pc_r;
  assign supervisor = sw_r[`EAG_SW_S];
  assign trace_active = sw_r[`EAG_SW_T];
  assign irq_mask = sw_r[`EAG_SW_MASK_HI:`EAG_SW_MASK_LO];
  assign cond_flags = sw_r[`EAG_SW_X:`EAG_SW_C];

endmodule // eag_core
`default_nettype wire

// ==== core/eag_ea_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eag_defs.svh"

module eag_ea_calc
(
  input wire eag_pkg::eag_req_t req,
  input wire logic [31:0] base,
  input wire logic [31:0] pc,
  input wire logic [31:0] index,
  output logic [31:0] ea,
  output logic [31:0] base_nxt,
  output logic base_upd,
  output logic is_mem
);

  logic [31:0] step;
  logic [31:0] short_displacement;
  logic [31:0] long_displacement;
  logic [31:0] idx_val;

  // ==========================================
  // Operand step and extended displacements
  always_comb
  begin
    case (req.size)
      eag_pkg::eag_sz_byte: step = `EAG_STEP_BYTE;
      eag_pkg::eag_sz_word: step = `EAG_STEP_WORD;
      eag_pkg::eag_sz_long: step = `EAG_STEP_LONG;
      default: step = `EAG_STEP_WORD;
    endcase
    short_displacement = {{24{req.ext_hi[7]}}, req.ext_hi[7:0]};
    long_displacement = {{16{req.ext_hi[15]}}, req.ext_hi};
    idx_val = req.idx_long ? index : {{16{index[15]}}, index[15:0]};
  end

  // ==========================================
  // Address formation per mode
  always_comb
  begin
    ea = 32'h0;
    base_nxt = base;
    base_upd = 1'b0;
    is_mem = 1'b1;
    case (req.mode)
      eag_pkg::eag_m_abs_short: ea = long_displacement;
      eag_pkg::eag_m_abs_long: ea = {req.ext_hi, req.ext_lo};
      eag_pkg::eag_m_pc_d16: ea = pc + long_displacement;
      eag_pkg::eag_m_pc_idx: ea = pc + idx_val + short_displacement;
      eag_pkg::eag_m_ind: ea = base;
      eag_pkg::eag_m_ind_d16: ea = base + long_displacement;
      eag_pkg::eag_m_ind_idx: ea = base + idx_val + short_displacement;
      eag_pkg::eag_m_postinc:
      begin
        ea = base;
        base_nxt = base + step;
        base_upd = 1'b1;
      end
      eag_pkg::eag_m_predec:
      begin
        base_nxt = base - step;
        ea = base_nxt;
        base_upd = 1'b1;
      end
      default: is_mem = 1'b0;
    endcase
  end

endmodule // eag_ea_calc
`default_nettype wire

// ==== include/eag_defs.svh ====
// How it works
// - Eight 32-bit data registers accept byte, word and long writes.
// - Seven address registers plus stack pointers serve as bases, word or long.
// - Any of seventeen general registers may be picked as the index.
// - A 32-bit program counter and 16-bit status word are held.
// - The effective address leaves on a 23-bit address bus.
// - The status word holds a three-bit interrupt mask of eight levels.
// - The status word holds extend, negative, zero, overflow and carry flags.
// - The status word holds a trace bit and a supervisor bit.
// - Absolute long uses two extension words; absolute short uses one.
// - PC-relative offset adds a 16-bit displacement to the program counter.
// - PC-relative indexed adds index and 8-bit displacement to the counter.
// - Indirect uses the address register; offset form adds a 16-bit displacement.
// - Indexed indirect adds index and 8-bit displacement to the address register.
// - Post-increment uses then adds N; pre-decrement subtracts N first.
// - Mode decoding takes all fourteen modes independent of the operation.
// - Operand size sets the address step and operand width.
// - Address register writes fill 32 bits; word sources are sign-extended.
// - Multibyte accesses need even addresses; second word at the effective address plus two.
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

// ==========================================
// Register selectors on the register port
`define EAG_SEL_D0 5'h00
`define EAG_SEL_A0 5'h08
`define EAG_SEL_USP 5'h0f
`define EAG_SEL_SSP 5'h10
`define EAG_SEL_PC 5'h11
`define EAG_SEL_SW 5'h12

// ==========================================
// Status word fields
`define EAG_SW_C 0
`define EAG_SW_V 1
`define EAG_SW_Z 2
`define EAG_SW_N 3
`define EAG_SW_X 4
`define EAG_SW_MASK_LO 8
`define EAG_SW_MASK_HI 10
`define EAG_SW_S 13
`define EAG_SW_T 15
`define EAG_SW_IMPL 16'ha71f

// ==========================================
// Reset values
`define EAG_SW_RST 16'h2700
`define EAG_REG_RST 32'h0000_0000
`define EAG_PC_RST 32'h0000_0000

// ==========================================
// Address steps and bus width
`define EAG_STEP_BYTE 32'h0000_0001
`define EAG_STEP_WORD 32'h0000_0002
`define EAG_STEP_LONG 32'h0000_0004
`define EAG_LONG_NEXT 32'h0000_0002
`define EAG_ABUS_HI 23
`define EAG_ABUS_LO 1

`endif

// ==== include/eag_pkg.sv ====
package eag_pkg;

  typedef enum logic [13:0]
  {
    eag_m_dreg = 14'h0001,
    eag_m_areg = 14'h0002,
    eag_m_abs_short = 14'h0004,
    eag_m_abs_long = 14'h0008,
    eag_m_pc_d16 = 14'h0010,
    eag_m_pc_idx = 14'h0020,
    eag_m_ind = 14'h0040,
    eag_m_postinc = 14'h0080,
    eag_m_predec = 14'h0100,
    eag_m_ind_d16 = 14'h0200,
    eag_m_ind_idx = 14'h0400,
    eag_m_imm = 14'h0800,
    eag_m_quick = 14'h1000,
    eag_m_implied = 14'h2000
  } eag_mode_t;

  typedef enum logic [1:0]
  {
    eag_sz_byte = 2'h0,
    eag_sz_word = 2'h1,
    eag_sz_long = 2'h2
  } eag_size_t;

  typedef struct packed
  {
    eag_mode_t mode;
    logic [2:0] reg_num;
    eag_size_t size;
    logic [4:0] idx_sel;
    logic idx_long;
    logic [15:0] ext_hi;
    logic [15:0] ext_lo;
  } eag_req_t;

  typedef struct packed
  {
    logic [31:0] effective_address;
    logic [31:0] operand;
    logic is_mem;
    logic addr_err;
  } eag_res_t;

endpackage
